/* ashp_port.sv */
// frame-synchronised serial host port of a measurement converter
// assumes the conversion core supplies result words and calibration events on clk
// Functional notes
// - self-clocking: serial clock starts only after transmit or receive frame goes low
// - self-clocking: receive frame low enables both clock and data drivers, unless a result read finds ready high
// - external clocking: data driver enabled only after receive frame low
// - ready output falls when a fresh result word is available
// - ready returns high after the last bit of a result word leaves
// - ready also falls when calibration finishes
// - result read drives data only with receive frame low and ready low
// - written bits are sampled on rising serial clock while transmit frame low
// - result is straight binary when unipolar, offset binary when bipolar
// - one data line writes control or calibration, reads control, calibration, result
// - compensation current follows a bit of the control word
// - strap high selects self-clocking, low selects host-supplied clock
// - register select low targets control, high targets result or calibration
// - self-clocking: clock released on frame high or when word is complete
// - control loads only after 24 bits; shorter frames dropped, extra clocks ignored
`timescale 1ns/10ps
module ashp_port
	import ashp_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic self_clock_strap,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic transmit_frame_n,
	input wire logic receive_frame_n,
	input wire logic register_select,
	input wire logic serial_io_line_in,
	output logic serial_io_line_out,
	output logic serial_io_line_oe,
	output logic word_ready_n,
	input wire logic [23:0] result_raw,
	input wire logic result_valid,
	input wire logic cal_done,
	input wire logic cal_select,
	input wire logic [23:0] cal_read_word,
	output logic [23:0] cal_write_word,
	output logic cal_write_pulse,
	output logic [23:0] control_word,
	output logic comp_current_en
);

	ashp_pins_type pins_raw;
	ashp_pins_type pins_s;
	ashp_state_type state_reg;
	logic [4:0] bit_cnt_reg;
	logic [23:0] shift_reg;
	logic [23:0] result_hold_reg;
	logic [23:0] ctrl_reg;
	logic [23:0] result_coded;
	logic target_high_reg;
	logic read_result_reg;
	logic ready_n_reg;
	logic oe_reg;
	logic ext_sclk_prev_reg;
	logic cal_pulse_reg;
	logic [23:0] cal_word_reg;
	logic div_run;
	logic div_level;
	logic div_rise;
	logic div_fall;
	logic bit_rise;
	logic bit_fall;
	logic frame_busy;
	logic last_rise;
	logic read_complete;

	assign pins_raw = '{self_clock: self_clock_strap, transmit_frame_n: transmit_frame_n,
		receive_frame_n: receive_frame_n, register_select: register_select,
		serial_in: serial_io_line_in, sclk: sclk_in};

	ashp_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.pins_in(pins_raw),
		.pins_out(pins_s)
	);

	assign frame_busy = (state_reg == ASHP_WRITE) || (state_reg == ASHP_READ);
	assign div_run = pins_s.self_clock && frame_busy;

	ashp_sclk_div u_div (
		.clk(clk),
		.rstn(rstn),
		.run(div_run),
		.sclk_level(div_level),
		.rise(div_rise),
		.fall(div_fall)
	);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ext_sclk_prev_reg <= 1'b1;
		else
			ext_sclk_prev_reg <= pins_s.sclk;
	end

	// strap picks the edge source; the synchronised copy of the host clock is only seen in external mode
	assign bit_rise = pins_s.self_clock ? div_rise : (pins_s.sclk && !ext_sclk_prev_reg);
	assign bit_fall = pins_s.self_clock ? div_fall : (!pins_s.sclk && ext_sclk_prev_reg);

	assign sclk_out = div_level;
	assign sclk_oe = div_run;

	assign last_rise = bit_rise && (bit_cnt_reg == ASHP_LAST_BIT);
	assign read_complete = (state_reg == ASHP_READ) && last_rise && read_result_reg;

	// frame sequencing; a write frame wins if both strobes fall together
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= ASHP_IDLE;
			bit_cnt_reg <= ASHP_CNT_ZERO;
			target_high_reg <= 1'b0;
			read_result_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ASHP_IDLE:
				begin
					bit_cnt_reg <= ASHP_CNT_ZERO;
					target_high_reg <= pins_s.register_select;
					if (!pins_s.transmit_frame_n)
					begin
						state_reg <= ASHP_WRITE;
						read_result_reg <= 1'b0;
					end
					else if (!pins_s.receive_frame_n)
					begin
						read_result_reg <= pins_s.register_select && !cal_select;
						// no result pending: the frame is held off with both drivers quiet
						if (pins_s.register_select && !cal_select && ready_n_reg)
							state_reg <= ASHP_DONE;
						else
							state_reg <= ASHP_READ;
					end
				end
				ASHP_WRITE:
				begin
					if (pins_s.transmit_frame_n)
						state_reg <= ASHP_IDLE;
					else if (bit_rise)
					begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (last_rise)
							state_reg <= ASHP_DONE;
					end
				end
				ASHP_READ:
				begin
					if (pins_s.receive_frame_n)
						state_reg <= ASHP_IDLE;
					else if (bit_rise)
					begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (last_rise)
							state_reg <= ASHP_DONE;
					end
				end
				ASHP_DONE:
				begin
					// extra clocks are ignored until both strobes return high
					if (pins_s.transmit_frame_n && pins_s.receive_frame_n)
						state_reg <= ASHP_IDLE;
				end
				default:
					state_reg <= ASHP_IDLE;
			endcase
		end
	end

	// one shift register serves both directions of the single data line
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			shift_reg <= ASHP_WORD_ZERO;
		else if (state_reg == ASHP_IDLE)
		begin
			if (!pins_s.register_select)
				shift_reg <= ctrl_reg;
			else if (cal_select)
				shift_reg <= cal_read_word;
			else
				shift_reg <= result_hold_reg;
		end
		else if (state_reg == ASHP_WRITE && bit_rise && !pins_s.transmit_frame_n)
			shift_reg <= {shift_reg[22:0], pins_s.serial_in};
		else if (state_reg == ASHP_READ && bit_fall && bit_cnt_reg != ASHP_CNT_ZERO)
			shift_reg <= {shift_reg[22:0], 1'b0};
	end

	assign serial_io_line_out = shift_reg[23];

	// driver turns off when receive frame rises or, in external mode only, at the first fall after the last bit so the host keeps hold time
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			oe_reg <= 1'b0;
		else if (state_reg == ASHP_READ)
			oe_reg <= !pins_s.receive_frame_n;
		else if (state_reg == ASHP_DONE && oe_reg)
			oe_reg <= !(bit_fall || pins_s.receive_frame_n);
		else
			oe_reg <= 1'b0;
	end

	assign serial_io_line_oe = oe_reg;

	// control word and calibration writes commit only on the 24th rising edge
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_reg <= ASHP_CTRL_RESET;
			cal_word_reg <= ASHP_WORD_ZERO;
			cal_pulse_reg <= 1'b0;
		end
		else
		begin
			cal_pulse_reg <= 1'b0;
			if (state_reg == ASHP_WRITE && last_rise && !pins_s.transmit_frame_n)
			begin
				if (!target_high_reg)
					ctrl_reg <= {shift_reg[22:0], pins_s.serial_in};
				else
				begin
					cal_word_reg <= {shift_reg[22:0], pins_s.serial_in};
					cal_pulse_reg <= 1'b1;
				end
			end
		end
	end

	assign control_word = ctrl_reg;
	assign cal_write_word = cal_word_reg;
	assign cal_write_pulse = cal_pulse_reg;
	assign comp_current_en = ctrl_reg[ASHP_CTRL_COMP_CUR_BIT];

	// core hands two's complement when bipolar; flipping the sign bit gives offset binary
	assign result_coded = ctrl_reg[ASHP_CTRL_UNIPOLAR_BIT] ? result_raw :
		{!result_raw[23], result_raw[22:0]};

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			result_hold_reg <= ASHP_WORD_ZERO;
		else if (result_valid)
			result_hold_reg <= result_coded;
	end

	// a new word or calibration end in the same cycle as a completed read keeps ready low
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ready_n_reg <= 1'b1;
		else if (result_valid || cal_done)
			ready_n_reg <= 1'b0;
		else if (read_complete)
			ready_n_reg <= 1'b1;
	end

	assign word_ready_n = ready_n_reg;

	property p_sclk_strap;
		@(posedge clk) disable iff (!rstn)
		sclk_oe |-> pins_s.self_clock;
	endproperty
	a_sclk_strap: assert property (p_sclk_strap) else $error("serial clock driven in external mode");

	property p_sclk_start;
		@(posedge clk) disable iff (!rstn)
		$rose(sclk_oe) |-> $past(!pins_s.transmit_frame_n || !pins_s.receive_frame_n);
	endproperty
	a_sclk_start: assert property (p_sclk_start) else $error("serial clock started without a frame");

	property p_sclk_release;
		@(posedge clk) disable iff (!rstn)
		(sclk_oe && ((pins_s.transmit_frame_n && pins_s.receive_frame_n) || last_rise)) |=> !sclk_oe;
	endproperty
	a_sclk_release: assert property (p_sclk_release) else $error("serial clock not released");

	property p_ready_fall;
		@(posedge clk) disable iff (!rstn)
		(result_valid || cal_done) |=> !word_ready_n;
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready did not fall on new word or calibration");

	property p_ready_rise;
		@(posedge clk) disable iff (!rstn)
		(read_complete && !result_valid && !cal_done) |=> word_ready_n ##1 (word_ready_n || $past(result_valid || cal_done));
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready not returned high after result word");

	property p_data_gate;
		@(posedge clk) disable iff (!rstn)
		$rose(serial_io_line_oe) && read_result_reg |-> $past(!word_ready_n, 2) && $past(!pins_s.receive_frame_n);
	endproperty
	a_data_gate: assert property (p_data_gate) else $error("result driven without ready low");

	property p_oe_frame;
		@(posedge clk) disable iff (!rstn)
		serial_io_line_oe |-> $past(!pins_s.receive_frame_n);
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("data driver on without receive frame");

	property p_ctrl_load;
		@(posedge clk) disable iff (!rstn)
		(state_reg == ASHP_WRITE && last_rise && !pins_s.transmit_frame_n && !target_high_reg)
		|=> ctrl_reg == $past({shift_reg[22:0], pins_s.serial_in});
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control word not loaded on 24th bit");

	property p_ctrl_hold;
		@(posedge clk) disable iff (!rstn)
		(state_reg != ASHP_WRITE || !last_rise) |=> $stable(ctrl_reg);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("control word changed without full write");

	property p_coding;
		@(posedge clk) disable iff (!rstn)
		result_valid |=> result_hold_reg == ($past(ctrl_reg[ASHP_CTRL_UNIPOLAR_BIT]) ? $past(result_raw) :
			{!$past(result_raw[23]), $past(result_raw[22:0])});
	endproperty
	a_coding: assert property (p_coding) else $error("result coding wrong for range");

	property p_comp_current;
		@(posedge clk) disable iff (!rstn)
		comp_current_en == control_word[ASHP_CTRL_COMP_CUR_BIT] ##1 $changed(ctrl_reg) |-> $past(last_rise);
	endproperty
	a_comp_current: assert property (p_comp_current) else $error("compensation enable moved without a write");

endmodule

/* ashp_pkg.sv */
// constants, pin bundle and state codes shared by the serial host port files
// assumes a single 250 MHz system clock; pins arrive from outside that domain
package ashp_pkg;

	localparam int ASHP_WORD_BITS = 24;
	localparam logic [4:0] ASHP_LAST_BIT = 5'h17;
	localparam logic [4:0] ASHP_CNT_ZERO = 5'h00;

	// control word field positions
	localparam int ASHP_CTRL_UNIPOLAR_BIT = 12;
	localparam int ASHP_CTRL_COMP_CUR_BIT = 14;
	localparam logic [23:0] ASHP_CTRL_RESET = 24'h000000;
	localparam logic [23:0] ASHP_WORD_ZERO = 24'h000000;

	// self-clocking serial clock: 32 ns period
	localparam int ASHP_CLK_PERIOD_NS = 4;
	localparam int ASHP_SCLK_HALF_NS = 16;
	localparam int ASHP_SCLK_HALF_CYC_INT = (ASHP_SCLK_HALF_NS + ASHP_CLK_PERIOD_NS - 1) / ASHP_CLK_PERIOD_NS;
	localparam logic [3:0] ASHP_SCLK_HALF_CYC = 4'(ASHP_SCLK_HALF_CYC_INT);
	localparam logic [3:0] ASHP_DIV_ZERO = 4'h0;

	localparam int ASHP_SYNC_STAGES = 2;

	typedef struct packed {
		logic self_clock;
		logic transmit_frame_n;
		logic receive_frame_n;
		logic register_select;
		logic serial_in;
		logic sclk;
	} ashp_pins_type;

	// idle pins: self clocking, both strobes high, select and data low, serial clock high
	localparam ashp_pins_type ASHP_PINS_IDLE = 6'h39;

	typedef enum logic [1:0] {
		ASHP_IDLE = 2'b00,
		ASHP_WRITE = 2'b01,
		ASHP_READ = 2'b10,
		ASHP_DONE = 2'b11
	} ashp_state_type;

endpackage

/* ashp_sync.sv */
// two-stage synchroniser for a bundle of pin levels
// assumes every bit is a slow level or an edge no faster than two clocks
`timescale 1ns/10ps
module ashp_sync
	import ashp_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input ashp_pins_type pins_in,
	output ashp_pins_type pins_out
);

	ashp_pins_type meta_reg;
	ashp_pins_type sync_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= ASHP_PINS_IDLE;
			sync_reg <= ASHP_PINS_IDLE;
		end
		else
		begin
			meta_reg <= pins_in;
			sync_reg <= meta_reg;
		end
	end

	assign pins_out = sync_reg;

endmodule

/* ashp_sclk_div.sv */
// serial clock generator for self-clocking mode
// idles high while not running; rise and fall are one-cycle pulses aligned to the toggles
`timescale 1ns/10ps
module ashp_sclk_div
	import ashp_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	output logic sclk_level,
	output logic rise,
	output logic fall
);

	logic [3:0] div_reg;
	logic sclk_reg;
	logic tick;

	assign tick = run && (div_reg == ASHP_SCLK_HALF_CYC - 4'h1);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			div_reg <= ASHP_DIV_ZERO;
		else if (!run || tick)
			div_reg <= ASHP_DIV_ZERO;
		else
			div_reg <= div_reg + 4'h1;
	end

	// a stopped clock parks high so the next frame opens with a falling edge
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sclk_reg <= 1'b1;
		else if (!run)
			sclk_reg <= 1'b1;
		else if (tick)
			sclk_reg <= !sclk_reg;
	end

	assign sclk_level = sclk_reg;
	assign rise = tick && !sclk_reg;
	assign fall = tick && sclk_reg;

endmodule

/* ashp_host_model.sv */
// host serial port model: opens frames, follows or makes the serial clock, shifts 24-bit words MSB first
// assumes the bench resolves the shared clock and data lines and feeds them back here
`timescale 1ns/10ps
module ashp_host_model
(
	input wire logic clk,
	input wire logic self_mode,
	input wire logic sclk_line,
	input wire logic data_line,
	input wire logic drv_oe,
	output logic transmit_frame_n,
	output logic receive_frame_n,
	output logic register_select,
	output logic host_sclk,
	output logic host_data,
	output logic host_data_oe
);
	int drv_cycles = 0;

	initial
	begin
		transmit_frame_n = 1'b1;
		receive_frame_n = 1'b1;
		register_select = 1'b0;
		host_sclk = 1'b1;
		host_data = 1'b0;
		host_data_oe = 1'b0;
	end

	always @(posedge clk)
		if (!receive_frame_n && drv_oe)
			drv_cycles <= drv_cycles + 1;

	// bounded so that a clock the device never starts cannot hang the run
	task automatic follow(input logic lvl);
		int n;
		n = 0;
		while (sclk_line !== lvl && n < 40)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic transfer(input logic wr, input logic sel, input logic [23:0] din, input int nbits,
		output logic [23:0] dout);
		dout = 24'h000000;
		@(posedge clk);
		register_select <= sel;
		host_data_oe <= wr;
		@(posedge clk);
		if (wr)
			transmit_frame_n <= 1'b0;
		else
			receive_frame_n <= 1'b0;
		repeat (6) @(posedge clk);
		for (int i = 0; i < nbits; i++)
		begin
			if (self_mode)
				follow(1'b0);
			else
				host_sclk <= 1'b0;
			// data changes only while the clock is low, so it is settled at the sampling rise
			host_data <= (i < 24) ? din[23 - i] : 1'b0;
			if (self_mode)
				follow(1'b1);
			else
				repeat (4) @(posedge clk);
			if (i < 24)
				dout = {dout[22:0], data_line};
			if (!self_mode)
			begin
				host_sclk <= 1'b1;
				repeat (4) @(posedge clk);
			end
		end
		repeat (4) @(posedge clk);
		transmit_frame_n <= 1'b1;
		receive_frame_n <= 1'b1;
		host_data_oe <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
endmodule

/* test_ashp_port.sv */
// self-checking bench of the serial host port against a host model
// assumes the port's own assertions sit in the design files
`timescale 1ns/10ps
module test_ashp_port
	import ashp_pkg::*;
;
	logic clk = 1'b0;
	logic rstn, strap, res_valid, cal_done, cal_select, sclk_last, d_last;
	logic [23:0] result_raw, cal_read_word, rd;
	logic sclk_out, sclk_oe, io_out, io_oe, word_ready_n, cal_write_pulse, comp_current_en;
	logic [23:0] cal_write_word, control_word;
	logic tfs_n, rfs_n, sel, host_sclk, host_d, host_d_oe;
	wire logic sclk_line;
	wire logic data_line;
	int miscompares = 0;
	int num_checks = 0;
	int cal_pulses = 0;
	int drv0;

	always #2 clk = ~clk;

	// a released line shows no stale level: it flips every cycle
	assign sclk_line = sclk_oe ? sclk_out : (strap ? ~sclk_last : host_sclk);
	assign data_line = io_oe ? io_out : (host_d_oe ? host_d : ~d_last);
	always @(posedge clk)
	begin
		sclk_last <= sclk_line;
		d_last <= data_line;
		if (cal_write_pulse === 1'b1)
			cal_pulses <= cal_pulses + 1;
	end

	ashp_port i_ashp_port (.clk(clk), .rstn(rstn), .self_clock_strap(strap), .sclk_in(sclk_line),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .transmit_frame_n(tfs_n), .receive_frame_n(rfs_n),
		.register_select(sel), .serial_io_line_in(data_line), .serial_io_line_out(io_out),
		.serial_io_line_oe(io_oe), .word_ready_n(word_ready_n), .result_raw(result_raw),
		.result_valid(res_valid), .cal_done(cal_done), .cal_select(cal_select),
		.cal_read_word(cal_read_word), .cal_write_word(cal_write_word), .cal_write_pulse(cal_write_pulse),
		.control_word(control_word), .comp_current_en(comp_current_en));

	ashp_host_model i_ashp_host_model (.clk(clk), .self_mode(strap), .sclk_line(sclk_line),
		.data_line(data_line), .drv_oe(io_oe), .transmit_frame_n(tfs_n), .receive_frame_n(rfs_n),
		.register_select(sel), .host_sclk(host_sclk), .host_data(host_d), .host_data_oe(host_d_oe));

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic xfer(input logic wr, input logic s, input logic [23:0] d, input int n);
		i_ashp_host_model.transfer(wr, s, d, n, rd);
	endtask

	task automatic pulse(input logic is_cal, input logic [23:0] raw);
		@(posedge clk);
		result_raw <= raw;
		res_valid <= !is_cal;
		cal_done <= is_cal;
		@(posedge clk);
		res_valid <= 1'b0;
		cal_done <= 1'b0;
		repeat (2) @(posedge clk);
		chk({23'h000000, word_ready_n}, 24'h000000);
	endtask

	task automatic t_reset();
		chk({19'h00000, word_ready_n, sclk_oe, io_oe, comp_current_en, cal_write_pulse}, 24'h000010);
		chk(control_word, ASHP_CTRL_RESET);
	endtask

	task automatic t_ctrl_self();
		strap <= 1'b1;
		repeat (4) @(posedge clk);
		chk({23'h000000, sclk_oe}, 24'h000000);
		xfer(1'b1, 1'b0, 24'h5A4321, 24);
		chk(control_word, 24'h5A4321);
		chk({23'h000000, comp_current_en}, 24'h000001);
		chk({22'h000000, sclk_oe, io_oe}, 24'h000000);
		xfer(1'b0, 1'b0, 24'h000000, 24);
		chk(rd, 24'h5A4321);
	endtask

	task automatic t_ctrl_ext();
		strap <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(1'b1, 1'b0, 24'hFFFFFF, 12);
		chk(control_word, 24'h5A4321);
		xfer(1'b1, 1'b0, 24'h0A1000, 26);
		chk(control_word, 24'h0A1000);
		chk({23'h000000, comp_current_en}, 24'h000000);
	endtask

	task automatic t_result(input logic [23:0] raw, input logic [23:0] exp);
		cal_select <= 1'b0;
		pulse(1'b0, raw);
		xfer(1'b0, 1'b1, 24'h000000, 24);
		chk(rd, exp);
		chk({23'h000000, word_ready_n}, 24'h000001);
		chk({23'h000000, sclk_oe}, 24'h000000);
	endtask

	task automatic t_refused();
		drv0 = i_ashp_host_model.drv_cycles;
		xfer(1'b0, 1'b1, 24'h000000, 24);
		chk(24'(i_ashp_host_model.drv_cycles - drv0), 24'h000000);
	endtask

	task automatic t_cal();
		pulse(1'b1, 24'h000000);
		xfer(1'b1, 1'b1, 24'h3C5A69, 24);
		chk(cal_write_word, 24'h3C5A69);
		chk(24'(cal_pulses), 24'h000001);
		cal_select <= 1'b1;
		cal_read_word <= 24'hC3A596;
		xfer(1'b0, 1'b1, 24'h000000, 24);
		chk(rd, 24'hC3A596);
	endtask

	initial
	begin
		rstn = 1'b0;
		strap = 1'b1;
		res_valid = 1'b0;
		cal_done = 1'b0;
		cal_select = 1'b0;
		result_raw = 24'h000000;
		cal_read_word = 24'h000000;
		sclk_last = 1'b1;
		d_last = 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_ctrl_self();
		t_ctrl_ext();
		t_result(24'h812345, 24'h812345);
		xfer(1'b1, 1'b0, 24'h5A4321, 24);
		t_result(24'h812345, 24'h012345);
		strap <= 1'b1;
		t_result(24'h7FFFFF, 24'hFFFFFF);
		strap <= 1'b0;
		t_refused();
		t_cal();
		close_out();
	end

	// whole sequence needs about 2300 clocks
	initial
	begin
		#200000;
		miscompares++;
		close_out();
	end
endmodule
